/* design/atc_pkg.sv */
// register map, field positions and encodings of the timer clock and interrupt block
package atc_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 3;
  localparam int N_HOLD = 5;
  localparam int DIV_W = 10;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS = 10'h037;
  localparam logic [IDX_W-1:0] IDX_GTC = 10'h043;
  localparam logic [IDX_W-1:0] IDX_MASK = 10'h070;
  localparam logic [IDX_W-1:0] IDX_CTRL_A = 10'h0B0;
  localparam logic [IDX_W-1:0] IDX_CTRL_B = 10'h0B1;
  localparam logic [IDX_W-1:0] IDX_COUNT = 10'h0B2;
  localparam logic [IDX_W-1:0] IDX_CMP_A = 10'h0B3;
  localparam logic [IDX_W-1:0] IDX_CMP_B = 10'h0B4;
  localparam logic [IDX_W-1:0] IDX_ASYNC_STATUS_REGISTER = 10'h0B6;

  // flag and mask bit positions
  localparam int FLAG_OVF = 0;
  localparam int FLAG_CMP_A = 1;
  localparam int FLAG_CMP_B = 2;

  // async status register: bits 7:5 configuration, bits 4:0 update busy
  localparam int ASYNC_STATUS_REGISTER_CFG_LSB = 5;
  localparam int CFG_AS = 0;
  localparam int CFG_EXT = 1;
  localparam int CFG_ALT = 2;

  localparam int GTC_PSR = 1;
  localparam int CTRL_B_FORCE_A = 7;
  localparam int CTRL_B_WGM2 = 3;
  localparam int CTRL_A_WGM_LSB = 0;
  localparam int CTRL_A_COM_A_LSB = 6;
  localparam logic [7:0] CTRL_B_STORE_MASK = 8'h3F;

  // holding register slots, ordered as the busy bits
  localparam int HOLD_CTRL_B = 0;
  localparam int HOLD_CTRL_A = 1;
  localparam int HOLD_CMP_B = 2;
  localparam int HOLD_CMP_A = 3;
  localparam int HOLD_COUNT = 4;
  localparam logic [1:0] EDGE_LAST = 2'h1;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;

  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PC_FF = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_FF = 3'h3;
  localparam logic [2:0] WGM_PC_TOP = 3'h5;
  localparam logic [2:0] WGM_FAST_TOP = 3'h7;

  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [DIV_W-1:0] MASK_DIV1 = 10'h000;
  localparam logic [DIV_W-1:0] MASK_DIV8 = 10'h007;
  localparam logic [DIV_W-1:0] MASK_DIV32 = 10'h01F;
  localparam logic [DIV_W-1:0] MASK_DIV64 = 10'h03F;
  localparam logic [DIV_W-1:0] MASK_DIV128 = 10'h07F;
  localparam logic [DIV_W-1:0] MASK_DIV256 = 10'h0FF;
  localparam logic [DIV_W-1:0] MASK_DIV1024 = 10'h3FF;

  typedef enum {
    SEL_NONE, SEL_FLAGS, SEL_GTC, SEL_MASK, SEL_CTRL_A, SEL_CTRL_B,
    SEL_COUNT, SEL_CMP_A, SEL_CMP_B, SEL_ASYNC_STATUS_REGISTER
  } atc_sel_t;
endpackage : atc_pkg

/* design/atc_timer2_ctrl.sv */
// timer clock selection, prescaler, interrupt flags and channel a output with apb registers
//
// Summary of operation
// R01 - i/o clock default, async select uses pins
// R02 - oscillator pin source, pin pair claimed
// R03 - external clock accepted on oscillator pin
// R04 - alternate select uses alternate clock pin
// R05 - source, oscillator, pin claims per table
// R06 - prescale 1,8,32,64,128,256,1024 or stop
// R07 - prescaler reset bit restarts prescaler
// R08 - mask and flag bits 7:3 zero
// R09 - compare b irq needs mask, global, flag
// R10 - compare a irq needs mask, global, flag
// R11 - overflow irq needs mask, global, flag
// R12 - compare b match sets flag 2
// R13 - compare a match sets flag 1
// R14 - vector acknowledge clears its flag
// R15 - writing one clears a flag
// R16 - overflow flag, phase correct at bottom
// R17 - nonzero output mode overrides port pin
// R18 - output mode toggle, clear, set
// R19 - three waveform bits select counting mode
// R20 - async writes held, commit after two edges
// R21 - cpu clock above four times oscillator
// R22 - async pins synchronised before use
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
module atc_timer2_ctrl #(
  parameter int PRESC_BITS = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [atc_pkg::ADDR_W-1:0] paddr,
  input wire logic [atc_pkg::DATA_W-1:0] pwdata,
  output logic [atc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_input_pin,
  input wire logic alternate_clock_pin,
  input wire logic cpu_global_irq_enable,
  input wire logic [atc_pkg::IRQ_W-1:0] irq_vector_ack,
  input wire logic channel_a_direction_out,
  output logic [atc_pkg::IRQ_W-1:0] irq_request,
  output logic channel_a_output,
  output logic channel_a_output_enable,
  output logic osc_enable,
  output logic osc_input_pin_claimed,
  output logic osc_output_pin_claimed,
  output logic alternate_clock_pin_claimed
);
  if (PRESC_BITS < atc_pkg::DIV_W) begin : g_check
    $error("PRESC_BITS too small for divide by 1024");
  end

  typedef struct packed {
    logic [2:0] flags;
    logic [2:0] mask;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] count;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [2:0] cfg;
    logic [atc_pkg::N_HOLD-1:0] busy;
    logic [atc_pkg::N_HOLD-1:0][7:0] hold;
    logic [atc_pkg::N_HOLD-1:0][1:0] edges;
    logic [PRESC_BITS-1:0] presc;
    logic count_down, block_match, out_a;
    logic [1:0] pin_s1, pin_s2, pin_s3;
    logic [atc_pkg::DATA_W-1:0] rdata;
    logic err;
  } atc_state_t;

  atc_state_t s_reg, s_next;

  function automatic atc_pkg::atc_sel_t atc_decode(input logic [atc_pkg::ADDR_W-1:0] a);
    case (a[atc_pkg::ADDR_W-1:2])
      atc_pkg::IDX_FLAGS: atc_decode = atc_pkg::SEL_FLAGS;
      atc_pkg::IDX_GTC: atc_decode = atc_pkg::SEL_GTC;
      atc_pkg::IDX_MASK: atc_decode = atc_pkg::SEL_MASK;
      atc_pkg::IDX_CTRL_A: atc_decode = atc_pkg::SEL_CTRL_A;
      atc_pkg::IDX_CTRL_B: atc_decode = atc_pkg::SEL_CTRL_B;
      atc_pkg::IDX_COUNT: atc_decode = atc_pkg::SEL_COUNT;
      atc_pkg::IDX_CMP_A: atc_decode = atc_pkg::SEL_CMP_A;
      atc_pkg::IDX_CMP_B: atc_decode = atc_pkg::SEL_CMP_B;
      atc_pkg::IDX_ASYNC_STATUS_REGISTER: atc_decode = atc_pkg::SEL_ASYNC_STATUS_REGISTER;
      default: atc_decode = atc_pkg::SEL_NONE;
    endcase
  endfunction : atc_decode

  function automatic logic atc_com_apply(input logic [1:0] com, input logic cur);
    case (com)
      atc_pkg::COM_TOGGLE: atc_com_apply = ~cur;
      atc_pkg::COM_CLEAR: atc_com_apply = 1'b0;
      atc_pkg::COM_SET: atc_com_apply = 1'b1;
      default: atc_com_apply = cur;
    endcase
  endfunction : atc_com_apply

  function automatic logic [atc_pkg::DIV_W-1:0] atc_div_mask(input logic [2:0] cs);
    case (cs)
      atc_pkg::CS_DIV1: atc_div_mask = atc_pkg::MASK_DIV1;
      atc_pkg::CS_DIV8: atc_div_mask = atc_pkg::MASK_DIV8;
      atc_pkg::CS_DIV32: atc_div_mask = atc_pkg::MASK_DIV32;
      atc_pkg::CS_DIV64: atc_div_mask = atc_pkg::MASK_DIV64;
      atc_pkg::CS_DIV128: atc_div_mask = atc_pkg::MASK_DIV128;
      atc_pkg::CS_DIV256: atc_div_mask = atc_pkg::MASK_DIV256;
      default: atc_div_mask = atc_pkg::MASK_DIV1024;
    endcase
  endfunction : atc_div_mask

  atc_pkg::atc_sel_t sel;
  logic bus_wr, bus_setup, async_on, src_pin_edge, source_tick, timer_tick;
  logic is_fast, is_pc, is_nonpwm, match_a, match_b, force_a, psr_wr, down_nx, out_nx;
  logic [1:0] pin_edge, com_a;
  logic [2:0] wgm, set_ev, flag_clr;
  logic [7:0] top, cnt_nx;
  logic [atc_pkg::N_HOLD-1:0] wr_tgt, commit, apply_en;
  logic [atc_pkg::N_HOLD-1:0][7:0] apply_val;
  logic [atc_pkg::DATA_W-1:0] rd_mux;

  assign sel = atc_decode(paddr);
  assign bus_wr = psel & penable & pwrite;
  assign bus_setup = psel & ~penable;
  assign async_on = s_reg.cfg[atc_pkg::CFG_AS];
  // R22 edges seen only on the second and third stage
  assign pin_edge = s_reg.pin_s2 & ~s_reg.pin_s3;
  // R02 alternate select low picks oscillator pin, R03 R04 pick pin
  assign src_pin_edge = s_reg.cfg[atc_pkg::CFG_ALT] ? pin_edge[1] : pin_edge[0];
  // R01 i/o clock unless async select
  assign source_tick = async_on ? src_pin_edge : 1'b1;
  // R06 prescaler tap select, stop gives no tick
  assign timer_tick = (s_reg.ctrl_b[2:0] != atc_pkg::CS_STOP) & source_tick
    & ((s_reg.presc[atc_pkg::DIV_W-1:0] & atc_div_mask(s_reg.ctrl_b[2:0]))
       == atc_div_mask(s_reg.ctrl_b[2:0]));
  // R19 mode from three waveform bits
  assign wgm = {s_reg.ctrl_b[atc_pkg::CTRL_B_WGM2], s_reg.ctrl_a[atc_pkg::CTRL_A_WGM_LSB +: 2]};
  assign com_a = s_reg.ctrl_a[atc_pkg::CTRL_A_COM_A_LSB +: 2];
  assign is_fast = (wgm == atc_pkg::WGM_FAST_FF) | (wgm == atc_pkg::WGM_FAST_TOP);
  assign is_pc = (wgm == atc_pkg::WGM_PC_FF) | (wgm == atc_pkg::WGM_PC_TOP);
  assign is_nonpwm = (wgm == atc_pkg::WGM_NORMAL) | (wgm == atc_pkg::WGM_CTC);
  assign top = ((wgm == atc_pkg::WGM_CTC) | (wgm == atc_pkg::WGM_PC_TOP)
    | (wgm == atc_pkg::WGM_FAST_TOP)) ? s_reg.cmp_a : atc_pkg::COUNT_MAX;
  // R12 R13 compare matches, blocked after a counter write
  assign match_a = (s_reg.count == s_reg.cmp_a) & ~s_reg.block_match;
  assign match_b = (s_reg.count == s_reg.cmp_b) & ~s_reg.block_match;
  // R07 prescaler reset strobe
  assign psr_wr = bus_wr & (sel == atc_pkg::SEL_GTC) & pwdata[atc_pkg::GTC_PSR];

  assign wr_tgt[atc_pkg::HOLD_CTRL_B] = bus_wr & (sel == atc_pkg::SEL_CTRL_B);
  assign wr_tgt[atc_pkg::HOLD_CTRL_A] = bus_wr & (sel == atc_pkg::SEL_CTRL_A);
  assign wr_tgt[atc_pkg::HOLD_CMP_B] = bus_wr & (sel == atc_pkg::SEL_CMP_B);
  assign wr_tgt[atc_pkg::HOLD_CMP_A] = bus_wr & (sel == atc_pkg::SEL_CMP_A);
  assign wr_tgt[atc_pkg::HOLD_COUNT] = bus_wr & (sel == atc_pkg::SEL_COUNT);

  // R20 writes go straight in synchronously, via holding slots when async
  for (genvar i = 0; i < atc_pkg::N_HOLD; i++) begin : g_hold
    assign commit[i] = s_reg.busy[i] & src_pin_edge & (s_reg.edges[i] == atc_pkg::EDGE_LAST);
    assign apply_en[i] = async_on ? commit[i] : wr_tgt[i];
    assign apply_val[i] = async_on ? s_reg.hold[i] : pwdata[7:0];
  end

  assign force_a = apply_en[atc_pkg::HOLD_CTRL_B] & is_nonpwm
    & apply_val[atc_pkg::HOLD_CTRL_B][atc_pkg::CTRL_B_FORCE_A];
  // R15 one clears, R14 vector acknowledge clears
  assign flag_clr = ((bus_wr & (sel == atc_pkg::SEL_FLAGS)) ? pwdata[2:0] : 3'h0) | irq_vector_ack;

  // counter, direction, overflow and channel a waveform
  always_comb begin
    cnt_nx = s_reg.count;
    down_nx = s_reg.count_down;
    out_nx = s_reg.out_a;
    set_ev = 3'h0;
    if (timer_tick) begin
      case (wgm)
        atc_pkg::WGM_NORMAL, atc_pkg::WGM_CTC, atc_pkg::WGM_FAST_FF, atc_pkg::WGM_FAST_TOP: begin
          cnt_nx = (s_reg.count == top) ? atc_pkg::COUNT_BOTTOM : s_reg.count + 8'h01;
          // R16 overflow at max, or at top in fast pwm
          set_ev[atc_pkg::FLAG_OVF] = is_fast ? (s_reg.count == top)
            : (s_reg.count == atc_pkg::COUNT_MAX);
        end
        atc_pkg::WGM_PC_FF, atc_pkg::WGM_PC_TOP: begin
          if (!s_reg.count_down) begin
            if (s_reg.count == top) begin
              down_nx = 1'b1;
              cnt_nx = s_reg.count - 8'h01;
            end else begin
              cnt_nx = s_reg.count + 8'h01;
            end
          end else if (s_reg.count == atc_pkg::COUNT_BOTTOM) begin
            // R16 turn at bottom raises overflow
            down_nx = 1'b0;
            cnt_nx = s_reg.count + 8'h01;
            set_ev[atc_pkg::FLAG_OVF] = 1'b1;
          end else begin
            cnt_nx = s_reg.count - 8'h01;
          end
        end
        default: begin
          cnt_nx = s_reg.count;
        end
      endcase
      set_ev[atc_pkg::FLAG_CMP_A] = match_a;
      set_ev[atc_pkg::FLAG_CMP_B] = match_b;
      // R18 waveform action on match
      if (is_nonpwm) begin
        if (match_a) begin
          out_nx = atc_com_apply(com_a, s_reg.out_a);
        end
      end else if (is_fast) begin
        if (match_a) begin
          out_nx = (com_a == atc_pkg::COM_TOGGLE) ? (s_reg.ctrl_b[atc_pkg::CTRL_B_WGM2]
            ^ s_reg.out_a) : atc_com_apply(com_a, s_reg.out_a);
        end
        if (s_reg.count == top) begin
          if (com_a == atc_pkg::COM_CLEAR) begin
            out_nx = 1'b1;
          end else if (com_a == atc_pkg::COM_SET) begin
            out_nx = 1'b0;
          end
        end
      end else if (is_pc & match_a) begin
        if (com_a == atc_pkg::COM_CLEAR) begin
          out_nx = s_reg.count_down;
        end else if (com_a == atc_pkg::COM_SET) begin
          out_nx = ~s_reg.count_down;
        end else if (com_a == atc_pkg::COM_TOGGLE) begin
          out_nx = s_reg.ctrl_b[atc_pkg::CTRL_B_WGM2] ^ s_reg.out_a;
        end
      end
    end
    if (force_a) begin
      out_nx = atc_com_apply(com_a, out_nx);
    end
  end

  // R08 read mux, reserved bits zero
  always_comb begin
    rd_mux = '0;
    case (sel)
      atc_pkg::SEL_FLAGS: rd_mux[2:0] = s_reg.flags;
      atc_pkg::SEL_MASK: rd_mux[2:0] = s_reg.mask;
      atc_pkg::SEL_CTRL_A: rd_mux[7:0] = s_reg.ctrl_a;
      atc_pkg::SEL_CTRL_B: rd_mux[7:0] = s_reg.ctrl_b;
      atc_pkg::SEL_COUNT: rd_mux[7:0] = s_reg.count;
      atc_pkg::SEL_CMP_A: rd_mux[7:0] = s_reg.cmp_a;
      atc_pkg::SEL_CMP_B: rd_mux[7:0] = s_reg.cmp_b;
      atc_pkg::SEL_ASYNC_STATUS_REGISTER: rd_mux[7:0] = {s_reg.cfg, s_reg.busy};
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    s_next = s_reg;
    // R22 two flop synchronisers on clock pins
    s_next.pin_s1 = {alternate_clock_pin, osc_input_pin};
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.pin_s3 = s_reg.pin_s2;
    // R07 reset wins over counting
    if (psr_wr) begin
      s_next.presc = '0;
    end else if (source_tick) begin
      s_next.presc = s_reg.presc + 1'b1;
    end
    s_next.count = cnt_nx;
    s_next.count_down = down_nx;
    s_next.out_a = out_nx;
    if (timer_tick) begin
      s_next.block_match = 1'b0;
    end
    // R12 R13 R16 set wins over R14 R15 clear
    s_next.flags = (s_reg.flags & ~flag_clr) | set_ev;
    if (bus_wr & (sel == atc_pkg::SEL_MASK)) begin
      s_next.mask = pwdata[2:0];
    end
    // R05 async configuration bits
    if (bus_wr & (sel == atc_pkg::SEL_ASYNC_STATUS_REGISTER)) begin
      s_next.cfg = pwdata[atc_pkg::ASYNC_STATUS_REGISTER_CFG_LSB +: 3];
    end
    // R20 holding slots count two source edges
    for (int i = 0; i < atc_pkg::N_HOLD; i++) begin
      if (commit[i]) begin
        s_next.busy[i] = 1'b0;
      end else if (s_reg.busy[i] & src_pin_edge) begin
        s_next.edges[i] = s_reg.edges[i] + 2'h1;
      end
      if (async_on & wr_tgt[i]) begin
        s_next.hold[i] = pwdata[7:0];
        s_next.busy[i] = 1'b1;
        s_next.edges[i] = 2'h0;
      end
      if (!async_on) begin
        s_next.busy[i] = 1'b0;
      end
    end
    if (apply_en[atc_pkg::HOLD_CTRL_B]) begin
      s_next.ctrl_b = apply_val[atc_pkg::HOLD_CTRL_B] & atc_pkg::CTRL_B_STORE_MASK;
    end
    if (apply_en[atc_pkg::HOLD_CTRL_A]) begin
      s_next.ctrl_a = apply_val[atc_pkg::HOLD_CTRL_A];
    end
    if (apply_en[atc_pkg::HOLD_CMP_B]) begin
      s_next.cmp_b = apply_val[atc_pkg::HOLD_CMP_B];
    end
    if (apply_en[atc_pkg::HOLD_CMP_A]) begin
      s_next.cmp_a = apply_val[atc_pkg::HOLD_CMP_A];
    end
    if (apply_en[atc_pkg::HOLD_COUNT]) begin
      s_next.count = apply_val[atc_pkg::HOLD_COUNT];
      s_next.block_match = 1'b1;
    end
    if (bus_setup) begin
      s_next.rdata = rd_mux;
      s_next.err = (sel == atc_pkg::SEL_NONE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & s_reg.err;
  // R09 R10 R11 request needs flag, mask and global enable
  assign irq_request = s_reg.flags & s_reg.mask & {atc_pkg::IRQ_W{cpu_global_irq_enable}};
  assign channel_a_output = s_reg.out_a;
  // R17 override and driver enable
  assign channel_a_output_enable = (com_a != atc_pkg::COM_OFF) & channel_a_direction_out;
  // R05 oscillator and pin claims
  assign osc_enable = async_on & ~s_reg.cfg[atc_pkg::CFG_EXT];
  assign osc_input_pin_claimed = async_on
    & ~(s_reg.cfg[atc_pkg::CFG_EXT] & s_reg.cfg[atc_pkg::CFG_ALT]);
  assign osc_output_pin_claimed = async_on & ~s_reg.cfg[atc_pkg::CFG_EXT];
  assign alternate_clock_pin_claimed = async_on & s_reg.cfg[atc_pkg::CFG_ALT];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_reserved_zero;
    psel && penable && !pwrite && (sel == atc_pkg::SEL_FLAGS || sel == atc_pkg::SEL_MASK)
      |-> prdata[7:3] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero"); // R08
  property p_w1c;
    bus_wr && sel == atc_pkg::SEL_FLAGS && pwdata[0] && !set_ev[0] |=> !s_reg.flags[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear flag"); // R15
  property p_ack_clear;
    irq_vector_ack[1] && !set_ev[1] |=> !s_reg.flags[1];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("acknowledge did not clear"); // R14
  property p_match_flag;
    timer_tick && match_b |=> s_reg.flags[2];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("compare b flag not set"); // R12
  property p_irq_gate;
    irq_request[1] |-> cpu_global_irq_enable && s_reg.mask[1] && s_reg.flags[1];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enables"); // R10
  property p_presc_reset;
    psr_wr |=> s_reg.presc == '0;
  endproperty
  a_presc_reset: assert property (p_presc_reset) else $error("prescaler not reset"); // R07
  property p_async_commit;
    $fell(s_reg.busy[atc_pkg::HOLD_COUNT]) && $past(async_on)
      |-> $past(src_pin_edge) && $past(s_reg.edges[atc_pkg::HOLD_COUNT]) == atc_pkg::EDGE_LAST
      && s_reg.count == $past(s_reg.hold[atc_pkg::HOLD_COUNT]);
  endproperty
  a_async_commit: assert property (p_async_commit) else $error("bad held commit"); // R20
  property p_toggle;
    timer_tick && is_nonpwm && com_a == atc_pkg::COM_TOGGLE && match_a && !force_a
      |=> s_reg.out_a != $past(s_reg.out_a);
  endproperty
  a_toggle: assert property (p_toggle) else $error("output did not toggle"); // R18
  property p_ctc_wrap;
    timer_tick && wgm == atc_pkg::WGM_CTC && s_reg.count == s_reg.cmp_a && apply_en == '0
      |=> s_reg.count == atc_pkg::COUNT_BOTTOM;
  endproperty
  a_ctc_wrap: assert property (p_ctc_wrap) else $error("ctc did not wrap"); // R19
  property p_pc_ovf;
    timer_tick && is_pc && s_reg.count_down && s_reg.count == atc_pkg::COUNT_BOTTOM
      |=> s_reg.flags[0] && !s_reg.count_down;
  endproperty
  a_pc_ovf: assert property (p_pc_ovf) else $error("no overflow at bottom turn"); // R16
  c_irq: cover property (timer_tick && match_a ##1 irq_request[1]);
  c_commit: cover property (commit[atc_pkg::HOLD_COUNT]);
  c_pc_turn: cover property (set_ev[0] && is_pc);
endmodule : atc_timer2_ctrl

/* dv/atc_cpu.sv */
// cpu side model: apb master, global interrupt enable and vector acknowledge
`timescale 1ns/10ps
module atc_cpu (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [atc_pkg::ADDR_W-1:0] paddr,
  output logic [atc_pkg::DATA_W-1:0] pwdata,
  input wire logic [atc_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic gie,
  output logic [atc_pkg::IRQ_W-1:0] ack
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gie = 1'h0;
    ack = 3'h0;
  end
  // one transfer: setup, then access held until pready
  task xfer(input logic w, input logic [9:0] i, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  task gie_set(input logic v);
    @(posedge pclk);
    gie <= v;
  endtask : gie_set
  // vector taken: acknowledge one source for one cycle
  task vector(input int n);
    @(posedge pclk);
    ack <= 3'h1 << n;
    @(posedge pclk);
    ack <= 3'h0;
  endtask : vector
endmodule : atc_cpu

/* dv/testbench.sv */
// self-checking bench for the timer clock and interrupt block
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic osc_pin = 1'h0;
  logic psel, penable, pwrite, pready, pslverr, gie, dir_out, alt_pin;
  logic oa, oa_en, osc_en, c_in, c_out, c_alt, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] ack, irq;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  always #20 pclk = ~pclk;
  atc_timer2_ctrl u_atc_timer2_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_input_pin(osc_pin), .alternate_clock_pin(alt_pin), .cpu_global_irq_enable(gie),
    .irq_vector_ack(ack), .channel_a_direction_out(dir_out), .irq_request(irq),
    .channel_a_output(oa), .channel_a_output_enable(oa_en), .osc_enable(osc_en),
    .osc_input_pin_claimed(c_in), .osc_output_pin_claimed(c_out),
    .alternate_clock_pin_claimed(c_alt));
  atc_cpu u_atc_cpu (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .gie(gie),
    .ack(ack));
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end
  task chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    tests_run++;
    if (got !== x) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, x, got);
    end
  endtask : chk
  task wr(input logic [9:0] i, input logic [31:0] d);
    u_atc_cpu.xfer(1'h1, i, d, q, e);
  endtask : wr
  task rd(input string nm, input logic [9:0] i, input logic [31:0] x);
    u_atc_cpu.xfer(1'h0, i, 32'h0, q, e);
    chk(nm, x, q);
  endtask : rd
  task wait_irq(input int b, output int n);
    n = 0;
    @(negedge pclk);
    while (irq[b] !== 1'h1 && n < 20000) begin
      @(negedge pclk);
      n++;
    end
  endtask : wait_irq
  // pin clock kept at an eighth of pclk, below a quarter
  task pin_edges(input int k, input logic o);
    repeat (k) begin
      repeat (4) @(posedge pclk);
      {osc_pin, alt_pin} <= o ? 2'h2 : 2'h1;
      repeat (4) @(posedge pclk);
      {osc_pin, alt_pin} <= 2'h0;
    end
    repeat (4) @(posedge pclk);
  endtask : pin_edges
  task t_reset;
    rd("flags", atc_pkg::IDX_FLAGS, 32'h0);
    rd("mask", atc_pkg::IDX_MASK, 32'h0);
    rd("ctrl_a", atc_pkg::IDX_CTRL_A, 32'h0);
    rd("unmapped", 10'h3FF, 32'h0);
    chk("slverr", 32'h1, e);
    wr(atc_pkg::IDX_MASK, 32'hFF);
    rd("mask rsv", atc_pkg::IDX_MASK, 32'h7);
    $display("test reset done");
  endtask : t_reset
  task t_pins;
    logic a, x, l;
    for (int c = 0; c < 8; c++) begin
      a = c[0];
      x = c[1];
      l = c[2];
      if (!a && x) continue;
      wr(atc_pkg::IDX_ASYNC_STATUS_REGISTER, 32'(c << 5));
      @(negedge pclk);
      chk("osc on", a & ~x, osc_en);
      chk("in claim", a & ~(x & l), c_in);
      chk("out claim", a & ~x, c_out);
      chk("alt claim", a & l, c_alt);
    end
    wr(atc_pkg::IDX_ASYNC_STATUS_REGISTER, 32'h0);
    $display("test pins done");
  endtask : t_pins
  task t_ovf;
    int n;
    int dv[4] = '{1, 8, 32, 64};
    wr(atc_pkg::IDX_CMP_A, 32'h80);
    wr(atc_pkg::IDX_CMP_B, 32'h80);
    wr(atc_pkg::IDX_MASK, 32'h1);
    u_atc_cpu.gie_set(1'h1);
    for (int k = 0; k < 4; k++) begin
      wr(atc_pkg::IDX_CTRL_B, 32'h0);
      wr(atc_pkg::IDX_GTC, 32'h2);
      wr(atc_pkg::IDX_COUNT, 32'h0);
      wr(atc_pkg::IDX_FLAGS, 32'h7);
      wr(atc_pkg::IDX_CTRL_B, 32'(k + 1));
      wait_irq(0, n);
      chk("ovf period", 32'h1, 32'(n > 256 * dv[k] - 16 && n < 256 * dv[k] + 16));
    end
    u_atc_cpu.gie_set(1'h0);
    @(negedge pclk);
    chk("irq gie off", 32'h0, irq);
    wr(atc_pkg::IDX_CTRL_B, 32'h0);
    wr(atc_pkg::IDX_FLAGS, 32'h0);
    rd("flags kept", atc_pkg::IDX_FLAGS, 32'h7);
    wr(atc_pkg::IDX_FLAGS, 32'h1);
    rd("ovf cleared", atc_pkg::IDX_FLAGS, 32'h6);
    wr(atc_pkg::IDX_FLAGS, 32'hFF);
    rd("all cleared", atc_pkg::IDX_FLAGS, 32'h0);
    u_atc_cpu.gie_set(1'h1);
    $display("test overflow done");
  endtask : t_ovf
  task run_match(input logic [1:0] m, input logic x);
    int n;
    wr(atc_pkg::IDX_CTRL_A, {24'h0, m, 6'h0});
    wr(atc_pkg::IDX_COUNT, 32'h0);
    wr(atc_pkg::IDX_FLAGS, 32'h7);
    wr(atc_pkg::IDX_CTRL_B, 32'h1);
    wait_irq(1, n);
    wr(atc_pkg::IDX_CTRL_B, 32'h0);
    chk("oc level", x, oa);
  endtask : run_match
  task t_cmp;
    wr(atc_pkg::IDX_MASK, 32'h6);
    run_match(2'h3, 1'h1);
    run_match(2'h2, 1'h0);
    run_match(2'h1, 1'h1);
    chk("oc drive", 32'h1, oa_en);
    dir_out <= 1'h0;
    @(negedge pclk);
    chk("oc dir in", 32'h0, oa_en);
    @(posedge pclk);
    dir_out <= 1'h1;
    wr(atc_pkg::IDX_CTRL_A, 32'h0);
    @(negedge pclk);
    chk("oc off", 32'h0, oa_en);
    rd("match flags", atc_pkg::IDX_FLAGS, 32'h6);
    chk("irq both", 32'h6, irq);
    wr(atc_pkg::IDX_MASK, 32'h4);
    @(negedge pclk);
    chk("irq b only", 32'h4, irq);
    u_atc_cpu.vector(1);
    rd("ack a", atc_pkg::IDX_FLAGS, 32'h4);
    u_atc_cpu.vector(2);
    rd("ack b", atc_pkg::IDX_FLAGS, 32'h0);
    $display("test compare done");
  endtask : t_cmp
  task t_async;
    wr(atc_pkg::IDX_ASYNC_STATUS_REGISTER, 32'hA0);
    wr(atc_pkg::IDX_CMP_A, 32'h55);
    rd("busy", atc_pkg::IDX_ASYNC_STATUS_REGISTER, 32'hA8);
    rd("held", atc_pkg::IDX_CMP_A, 32'h80);
    pin_edges(2, 1'h1);
    rd("other pin", atc_pkg::IDX_ASYNC_STATUS_REGISTER, 32'hA8);
    pin_edges(2, 1'h0);
    rd("idle", atc_pkg::IDX_ASYNC_STATUS_REGISTER, 32'hA0);
    rd("landed", atc_pkg::IDX_CMP_A, 32'h55);
    wr(atc_pkg::IDX_ASYNC_STATUS_REGISTER, 32'h60);
    wr(atc_pkg::IDX_COUNT, 32'h3C);
    pin_edges(2, 1'h1);
    rd("count landed", atc_pkg::IDX_COUNT, 32'h3C);
    wr(atc_pkg::IDX_ASYNC_STATUS_REGISTER, 32'h0);
    $display("test async done");
  endtask : t_async
  task t_wave;
    int n;
    wr(atc_pkg::IDX_MASK, 32'h1);
    wr(atc_pkg::IDX_CMP_A, 32'h10);
    wr(atc_pkg::IDX_CTRL_A, 32'h2);
    wr(atc_pkg::IDX_COUNT, 32'h0);
    wr(atc_pkg::IDX_FLAGS, 32'h7);
    wr(atc_pkg::IDX_CTRL_B, 32'h1);
    repeat (100) @(posedge pclk);
    wr(atc_pkg::IDX_CTRL_B, 32'h0);
    rd("ctc flags", atc_pkg::IDX_FLAGS, 32'h2);
    u_atc_cpu.xfer(1'h0, atc_pkg::IDX_COUNT, 32'h0, q, e);
    chk("ctc top", 32'h1, 32'(q <= 32'h10));
    wr(atc_pkg::IDX_CTRL_A, 32'h1);
    wr(atc_pkg::IDX_COUNT, 32'h0);
    wr(atc_pkg::IDX_FLAGS, 32'h7);
    wr(atc_pkg::IDX_CTRL_B, 32'h1);
    wait_irq(0, n);
    chk("pc period", 32'h1, 32'(n > 500 && n < 520));
    wr(atc_pkg::IDX_CTRL_B, 32'h0);
    $display("test waveform done");
  endtask : t_wave
  task final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  initial begin
    dir_out = 1'h1;
    alt_pin = 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_pins();
    t_ovf();
    t_cmp();
    t_async();
    t_wave();
    final_report();
  end
endmodule : testbench
